// *** rtl/arb_pkg.sv ***
// Constants shared by the shared-memory arbiter and its register file.
// Assumes a 50 MHz bus clock and a 32-bit Avalon-MM register port.
package arb_pkg;
    localparam int CLK_MHZ = 50;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_DCR = 8'h04;
    localparam logic [7:0] OFF_DATA_CONFIG_REG_TWO = 8'h08;
    localparam logic [7:0] OFF_IMR = 8'h0c;
    localparam logic [7:0] OFF_ISR = 8'h10;
    localparam logic [7:0] OFF_TCR = 8'h14;
    localparam logic [7:0] OFF_RCR = 8'h18;
    localparam logic [7:0] OFF_BUFFER_END_COUNT = 8'h1c;
    localparam logic [7:0] OFF_SEQ = 8'h20;
    localparam logic [7:0] OFF_CAME = 8'h24;
    localparam logic [7:0] OFF_DMA = 8'h28;
    localparam logic [7:0] OFF_STAT = 8'h2c;
    localparam logic [15:0] CMD_HW_RST = 16'h0094;
    localparam logic [15:0] CMD_SW_RST = 16'h0094;
    localparam logic [15:0] CMD_SW_RST_TX = 16'h00a4;
    localparam logic [15:0] IMR_RST = 16'h0000;
    localparam logic [15:0] ISR_RST = 16'h0000;
    localparam logic [15:0] TCR_RST = 16'h0101;
    localparam logic [15:0] BUFFER_END_COUNT_RST = 16'h02f8;
    localparam logic [15:0] SEQ_RST = 16'h0000;
    localparam logic [15:0] CAME_RST = 16'h0000;
    localparam logic [15:0] RCR_HW_CLR = 16'h0e00;
    localparam logic [15:0] DCR_HW_CLR = 16'ha000;
    localparam logic [15:0] DATA_CONFIG_REG_TWO_HW_CLR = 16'h001f;
    localparam int CMD_SOFT_RESET_BIT = 7;
    localparam int CMD_TX_BIT = 1;
    localparam logic [2:0] MASTER_BASE_CLKS = 3'h4;
endpackage : arb_pkg

// *** rtl/req_sync.sv ***
// Two-stage synchroniser for the active-low memory request.
// Assumes the first stage samples on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module req_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_n,
    output logic sync_n
);
    logic fall_ff;
    logic rise_ff;
    // First stage on the falling edge gives a half cycle of resolution time
    always_ff @(negedge clk) begin
        fall_ff <= async_n;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rise_ff <= 1'b1;
        end else begin
            rise_ff <= fall_ff;
        end
    end
    assign sync_n = rise_ff;
endmodule : req_sync
`default_nettype wire

// *** rtl/wait_counter.sv ***
// Counts the cycles left in the current master transfer, one per base clock or wait state.
// Assumes a load pulse starts a transfer and a stall level adds wait states.
`timescale 1ns/1ps
`default_nettype none
module wait_counter #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic stall,
    output logic busy
);
    logic [W-1:0] cnt_ff;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0 && !stall) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end
    // Busy must not depend on load: the load itself is gated by busy
    assign busy = (cnt_ff != '0);
endmodule : wait_counter
`default_nettype wire

// *** rtl/mem_arbiter.sv ***
// Shared-memory arbiter with hardware and software reset of the register set.
// Assumes one 50 MHz clock and an Avalon-MM master on the register port.
// Behaviour
// - Host claims memory with mem_request_n; grant_ack_n grants; release ends it.
// - Request sampled on falling edge, then synchronised once to rising edge.
// - Grant issued at a first bus state, after finishing any current transfer.
// - Grant one clock after sampling when idle, five when mastering.
// - Each master wait state adds one clock to the grant delay.
// - Grant removed within one clock of release; master operation then resumes.
// - Chip select access arbitrated likewise, ending in a slave cycle.
// - Memory grant stays low continuously until request withdrawn.
// - Chip select grant also needs strobe at level set by bus style.
// - Hardware pin reset and software command reset act differently.
// - Hardware reset loads command register 0094h.
// - Hardware reset clears interrupt mask and flag registers.
// - Hardware reset loads transmit control 0101h.
// - Hardware reset loads buffer end count 02F8h.
// - Hardware reset clears sequence counters and match enable register.
// - Hardware reset clears loopback and broadcast bits only in receive control.
// - Hardware reset clears listed data configuration bits; others kept.
// - Hardware reset also clears the DMA request register; it leaves only the kept receive and data configuration bits untouched.
// - Software reset stops DMA, parks idle, changes only command and DMA request registers.
`timescale 1ns/1ps
`default_nettype none
module mem_arbiter
    import arb_pkg::*;
#(
    parameter int CNT_W = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic mem_request_n,
    input wire logic chip_sel_n,
    input wire logic slave_addr_strobe,
    input wire logic bus_style_select,
    input wire logic master_wait,
    output logic grant_ack_n,
    output logic bus_master,
    output logic slave_cycle,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [2:0] {ST_IDLE, ST_MASTER, ST_DRAIN, ST_MEM_GRANT, ST_SLAVE} arb_state_e;
    arb_state_e state_ff;
    arb_state_e nxt_state;
    logic req_sync_n;
    logic grant_ff;
    logic nxt_grant;
    logic master_ff;
    logic slave_ff;
    logic resume_ff;
    logic xfer_busy;
    logic xfer_load;
    logic ack_ff;
    logic grant_n_ff;
    logic wreq_ff;
    logic [31:0] rdata_ff;
    logic [15:0] cmd_ff;
    logic [15:0] dcr_ff;
    logic [15:0] data_config_reg_two_ff;
    logic [15:0] imr_ff;
    logic [15:0] isr_ff;
    logic [15:0] tcr_ff;
    logic [15:0] rcr_ff;
    logic [15:0] buffer_end_count_ff;
    logic [15:0] seq_ff;
    logic [15:0] came_ff;
    logic dma_req_ff;

    req_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_n(mem_request_n),
        .sync_n(req_sync_n)
    );

    wire mem_req = !req_sync_n;
    wire strobe_ok = bus_style_select ? !slave_addr_strobe : slave_addr_strobe;
    wire cs_req = !chip_sel_n && strobe_ok;
    wire host_req = mem_req || cs_req;
    wire bus_acc = (avs_read || avs_write) && !ack_ff;
    wire wr_hit = avs_write && !ack_ff;
    wire soft_rst = wr_hit && avs_address == OFF_CMD && avs_writedata[CMD_SOFT_RESET_BIT];
    wire dma_start = dma_req_ff && !soft_rst && !host_req;

    assign xfer_load = (state_ff == ST_IDLE || state_ff == ST_MASTER) && nxt_state == ST_MASTER
        && !xfer_busy;

    // Cycles beyond the grant edge: base of five minus the grant cycle itself
    wait_counter #(.W(CNT_W)) u_wait (
        .clk(clk),
        .resetn(resetn),
        .load(xfer_load),
        .load_val(CNT_W'(MASTER_BASE_CLKS)),
        .stall(master_wait),
        .busy(xfer_busy)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_grant = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (mem_req) begin
                    nxt_state = ST_MEM_GRANT;
                    nxt_grant = 1'b1;
                end else if (cs_req) begin
                    nxt_state = ST_SLAVE;
                    nxt_grant = 1'b1;
                end else if (dma_start || resume_ff) begin
                    nxt_state = ST_MASTER;
                end
            end
            ST_MASTER: begin
                if (soft_rst) begin
                    nxt_state = ST_IDLE;
                end else if (host_req) begin
                    nxt_state = ST_DRAIN;
                end else if (!xfer_busy && !dma_req_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_DRAIN: begin
                if (!xfer_busy) begin
                    if (mem_req) begin
                        nxt_state = ST_MEM_GRANT;
                        nxt_grant = 1'b1;
                    end else if (cs_req) begin
                        nxt_state = ST_SLAVE;
                        nxt_grant = 1'b1;
                    end else begin
                        nxt_state = ST_MASTER;
                    end
                end
            end
            ST_MEM_GRANT: begin
                if (mem_req) begin
                    nxt_grant = 1'b1;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SLAVE: begin
                if (cs_req) begin
                    nxt_grant = 1'b1;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            grant_ff <= 1'b0;
            grant_n_ff <= 1'b1;
            master_ff <= 1'b0;
            slave_ff <= 1'b0;
            resume_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            grant_ff <= nxt_grant;
            grant_n_ff <= !nxt_grant;
            master_ff <= nxt_state == ST_MASTER || nxt_state == ST_DRAIN;
            slave_ff <= nxt_state == ST_SLAVE;
            if (soft_rst) begin
                resume_ff <= 1'b0;
            end else if (state_ff == ST_DRAIN && nxt_state != ST_DRAIN && dma_req_ff) begin
                resume_ff <= 1'b1;
            end else if (nxt_state == ST_MASTER) begin
                resume_ff <= 1'b0;
            end
        end
    end

    assign grant_ack_n = grant_n_ff;
    assign bus_master = master_ff;
    assign slave_cycle = slave_ff;

    // One wait cycle for every access keeps the read path registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            wreq_ff <= 1'b1;
        end else begin
            ack_ff <= bus_acc;
            wreq_ff <= !bus_acc;
        end
    end
    assign avs_waitrequest = wreq_ff;

    function automatic logic [15:0] reg_sel(input logic [7:0] a, input logic [15:0] c,
            input logic [15:0] d, input logic [15:0] d2, input logic [15:0] im,
            input logic [15:0] is, input logic [15:0] t, input logic [15:0] r,
            input logic [15:0] e, input logic [15:0] s, input logic [15:0] cm);
        if (a == OFF_CMD) reg_sel = c;
        else if (a == OFF_DCR) reg_sel = d;
        else if (a == OFF_DATA_CONFIG_REG_TWO) reg_sel = d2;
        else if (a == OFF_IMR) reg_sel = im;
        else if (a == OFF_ISR) reg_sel = is;
        else if (a == OFF_TCR) reg_sel = t;
        else if (a == OFF_RCR) reg_sel = r;
        else if (a == OFF_BUFFER_END_COUNT) reg_sel = e;
        else if (a == OFF_SEQ) reg_sel = s;
        else if (a == OFF_CAME) reg_sel = cm;
        else reg_sel = 16'h0000;
    endfunction : reg_sel

    wire [15:0] stat_word = {11'h000, dma_req_ff, resume_ff, slave_ff, master_ff, grant_ff};
    wire [15:0] rd_word = avs_address == OFF_STAT ? stat_word :
        avs_address == OFF_DMA ? {15'h0000, dma_req_ff} :
        reg_sel(avs_address, cmd_ff, dcr_ff, data_config_reg_two_ff, imr_ff, isr_ff, tcr_ff, rcr_ff,
            buffer_end_count_ff, seq_ff, came_ff);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            rdata_ff <= {16'h0000, rd_word};
        end
    end
    assign avs_readdata = rdata_ff;

    wire [15:0] wd = avs_writedata[15:0];
    wire [15:0] sw_cmd = cmd_ff[CMD_TX_BIT] ? CMD_SW_RST_TX : CMD_SW_RST;

    // Registers with partial reset have no reset branch on the kept bits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_ff <= CMD_HW_RST;
            imr_ff <= IMR_RST;
            isr_ff <= ISR_RST;
            tcr_ff <= TCR_RST;
            buffer_end_count_ff <= BUFFER_END_COUNT_RST;
            seq_ff <= SEQ_RST;
            came_ff <= CAME_RST;
            dma_req_ff <= 1'b0;
        end else if (soft_rst) begin
            cmd_ff <= sw_cmd;
            dma_req_ff <= 1'b0;
        end else if (wr_hit) begin
            if (avs_address == OFF_CMD) cmd_ff <= wd;
            if (avs_address == OFF_IMR) imr_ff <= wd;
            if (avs_address == OFF_ISR) isr_ff <= isr_ff & ~wd;
            if (avs_address == OFF_TCR) tcr_ff <= wd;
            if (avs_address == OFF_BUFFER_END_COUNT) buffer_end_count_ff <= wd;
            if (avs_address == OFF_SEQ) seq_ff <= wd;
            if (avs_address == OFF_CAME) came_ff <= wd;
            if (avs_address == OFF_DMA) dma_req_ff <= avs_writedata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rcr_ff <= rcr_ff & ~RCR_HW_CLR;
            dcr_ff <= dcr_ff & ~DCR_HW_CLR;
            data_config_reg_two_ff <= data_config_reg_two_ff & ~DATA_CONFIG_REG_TWO_HW_CLR;
        end else if (wr_hit) begin
            if (avs_address == OFF_RCR) rcr_ff <= wd;
            if (avs_address == OFF_DCR) dcr_ff <= wd;
            if (avs_address == OFF_DATA_CONFIG_REG_TWO) data_config_reg_two_ff <= wd;
        end
    end

    a_grant_holds: assert property (@(posedge clk) disable iff (!resetn)
        state_ff == ST_MEM_GRANT && mem_req |=> !grant_ack_n)
        else $error("memory grant dropped while request held");
    a_grant_release: assert property (@(posedge clk) disable iff (!resetn)
        state_ff == ST_MEM_GRANT && !mem_req |=> grant_ack_n)
        else $error("grant not removed after release");
    a_idle_grant: assert property (@(posedge clk) disable iff (!resetn)
        state_ff == ST_IDLE && mem_req |=> !grant_ack_n)
        else $error("idle grant not given in one clock");
    a_drain_no_grant: assert property (@(posedge clk) disable iff (!resetn)
        state_ff == ST_DRAIN && xfer_busy |=> grant_ack_n)
        else $error("grant during unfinished master transfer");
    a_slave_strobe: assert property (@(posedge clk) disable iff (!resetn)
        state_ff == ST_SLAVE && !cs_req |=> grant_ack_n)
        else $error("register grant held without strobe");
    a_grant_master: assert property (@(posedge clk) disable iff (!resetn)
        !grant_ack_n |-> !bus_master)
        else $error("grant while still bus master");
    a_soft_cmd: assert property (@(posedge clk) disable iff (!resetn)
        soft_rst |=> (cmd_ff == CMD_SW_RST || cmd_ff == CMD_SW_RST_TX) && !dma_req_ff)
        else $error("software reset command value wrong");
    a_hw_values: assert property (@(posedge clk)
        !resetn |=> cmd_ff == CMD_HW_RST && tcr_ff == TCR_RST && buffer_end_count_ff == BUFFER_END_COUNT_RST)
        else $error("hardware reset values wrong");
    a_reset_grant: assert property (@(posedge clk)
        !resetn |=> grant_ack_n && !bus_master)
        else $error("grant or mastership during reset");
endmodule : mem_arbiter
`default_nettype wire

// *** test/host_model.sv ***
// Host side model: claims shared memory or a register slot on command.
// Assumes one go pulse per claim; the spacing between claims is kept here.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic bus_style_select,
    input wire logic go,
    input wire logic use_cs,
    input wire logic [4:0] len,
    output logic mem_request_n,
    output logic chip_sel_n,
    output logic slave_addr_strobe,
    output logic idle
);
    logic [4:0] left_ff;
    logic [1:0] gap_ff;
    logic cs_ff;
    wire logic active = (left_ff != 5'h00);
    assign idle = !active && (gap_ff == 2'h0);
    assign mem_request_n = !(active && !cs_ff);
    assign chip_sel_n = !(active && cs_ff);
    // Strobe rests at the non-qualifying level so no stray grant can start
    assign slave_addr_strobe = chip_sel_n ? bus_style_select : !bus_style_select;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            left_ff <= 5'h00;
            gap_ff <= 2'h0;
            cs_ff <= 1'b0;
        end else if (go && idle) begin
            left_ff <= len;
            cs_ff <= use_cs;
        end else if (active) begin
            left_ff <= left_ff - 5'h01;
            gap_ff <= 2'h3;
        end else if (gap_ff != 2'h0) begin
            gap_ff <= gap_ff - 2'h1;
        end
    end
endmodule : host_model
`default_nettype wire

// *** test/tb_shared_mem_arbiter_reset.sv ***
// Self-checking bench for the shared-memory arbiter and its reset logic.
// Assumes the host model on the request pins and an Avalon master here.
`timescale 1ns/1ps
`default_nettype none
module tb_shared_mem_arbiter_reset
    import arb_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_style_select = 1'b1;
    logic master_wait = 1'b0;
    logic go = 1'b0;
    logic use_cs = 1'b0;
    logic [4:0] len = 5'h01;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire logic mem_request_n, chip_sel_n, slave_addr_strobe, host_idle;
    wire logic grant_ack_n, bus_master, slave_cycle, avs_waitrequest;
    wire logic [31:0] avs_readdata;
    int seed = 93399;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic g_prev = 1'b1;
    logic [15:0] rq[$];
    logic [15:0] mq[$];
    int lo_q[$];
    int hi_q[$];
    mem_arbiter u_mem_arbiter (.clk(clk), .resetn(resetn), .mem_request_n(mem_request_n),
        .chip_sel_n(chip_sel_n), .slave_addr_strobe(slave_addr_strobe),
        .bus_style_select(bus_style_select), .master_wait(master_wait),
        .grant_ack_n(grant_ack_n), .bus_master(bus_master), .slave_cycle(slave_cycle),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    host_model u_host_model (.clk(clk), .resetn(resetn), .bus_style_select(bus_style_select),
        .go(go), .use_cs(use_cs), .len(len), .mem_request_n(mem_request_n),
        .chip_sel_n(chip_sel_n), .slave_addr_strobe(slave_addr_strobe), .idle(host_idle));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic err(input string msg);
        num_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : err
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic is_rd, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= is_rd;
        avs_write <= !is_rd;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            err("bus timeout");
            end_of_test();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        rq.push_back(e);
        mq.push_back(m);
        bus(1'b1, a, 32'($random(seed)));
    endtask : rd
    // Waits for a signal: 0 grant, 1 master, 2 slave, 3 host idle, 4 lines released
    task automatic wsig(input int s, input logic v, input int n);
        int i;
        logic x;
        n_checks++;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            x = (s == 0) ? grant_ack_n : (s == 1) ? bus_master : (s == 2) ? slave_cycle :
                (s == 3) ? host_idle : (mem_request_n & chip_sel_n);
            if (x === v) return;
        end
        err("signal did not settle");
        end_of_test();
    endtask : wsig
    task automatic claim(input logic cs, input logic [4:0] n, input int lo, input int wt);
        wsig(3, 1'b1, 40);
        @(posedge clk);
        go <= 1'b1;
        use_cs <= cs;
        len <= n;
        master_wait <= (wt > 0);
        // Drain time depends on how far the running transfer has got
        lo_q.push_back(cyc + lo);
        hi_q.push_back(cyc + lo + wt + 3);
        @(posedge clk);
        go <= 1'b0;
        if (wt > 1) repeat (wt - 1) @(posedge clk);
        master_wait <= 1'b0;
    endtask : claim
    task automatic chk_tbl(input logic w);
        rd(OFF_CMD, 16'h0094, 16'hffff);
        rd(OFF_IMR, 16'h0000, 16'hffff);
        rd(OFF_ISR, 16'h0000, 16'hffff);
        rd(OFF_TCR, 16'h0101, 16'hffff);
        rd(OFF_BUFFER_END_COUNT, 16'h02f8, 16'hffff);
        rd(OFF_SEQ, 16'h0000, 16'hffff);
        rd(OFF_CAME, 16'h0000, 16'hffff);
        rd(OFF_RCR, w ? 16'hf1ff : 16'h0000, w ? 16'hffff : 16'h0e00);
        rd(OFF_DCR, w ? 16'h5fff : 16'h0000, w ? 16'hffff : 16'ha000);
        rd(OFF_DATA_CONFIG_REG_TWO, w ? 16'hffe0 : 16'h0000, w ? 16'hffff : 16'h001f);
        rd(8'h3c, 16'h0000, 16'hffff);
    endtask : chk_tbl
    always @(posedge clk) begin : watch
        logic [15:0] e;
        logic [15:0] m;
        int lo;
        int hi;
        cyc <= cyc + 1;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0) begin
            e = rq.pop_front();
            m = mq.pop_front();
            n_checks++;
            if (((avs_readdata[15:0] ^ e) & m) !== 16'h0000) err("read data");
        end
        if (g_prev === 1'b1 && grant_ack_n === 1'b0 && lo_q.size() > 0) begin
            lo = lo_q.pop_front();
            hi = hi_q.pop_front();
            n_checks++;
            if (cyc < lo || cyc > hi) err("grant delay");
        end
        if (g_prev === 1'b0 && grant_ack_n === 1'b1 && mem_request_n === 1'b0)
            err("memory grant dropped while requested");
        g_prev <= grant_ack_n;
    end
    initial begin : main
        int w;
        int a;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk_tbl(1'b0);
        $display("test reset values done");
        claim(1'b0, 5'h02 + {1'b0, 4'($random(seed))}, 4, 0);
        wsig(4, 1'b1, 40);
        wsig(0, 1'b1, 4);
        $display("test idle claim done");
        for (w = 0; w < 2; w++) begin
            bus_style_select <= w[0];
            claim(1'b1, 5'h06, 3, 0);
            wsig(2, 1'b1, 10);
            wsig(4, 1'b1, 20);
            wsig(0, 1'b1, 4);
        end
        $display("test register claim done");
        bus(1'b0, OFF_DMA, 32'h1);
        wsig(1, 1'b1, 10);
        for (w = 0; w < 2; w++) begin
            claim(1'b0, 5'h08, 5, w * (1 + ($random(seed) & 3)));
            wsig(4, 1'b1, 40);
            wsig(0, 1'b1, 4);
            wsig(1, 1'b1, 10);
        end
        $display("test master claim done");
        bus(1'b0, OFF_IMR, 32'h1234);
        bus(1'b0, OFF_CMD, 32'h0080);
        wsig(1, 1'b0, 10);
        rd(OFF_CMD, 16'h0094, 16'hffff);
        rd(OFF_IMR, 16'h1234, 16'hffff);
        rd(OFF_TCR, 16'h0101, 16'hffff);
        bus(1'b0, OFF_CMD, 32'h0002);
        bus(1'b0, OFF_CMD, 32'h0080);
        rd(OFF_CMD, 16'h00a4, 16'hffff);
        $display("test soft reset done");
        for (a = 4; a <= 8'h24; a += 4) bus(1'b0, 8'(a), {16'($random(seed)), 16'hffff});
        bus(1'b0, 8'h3c, 32'hffff);
        claim(1'b0, 5'h1f, 4, 0);
        wsig(0, 1'b0, 10);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        n_checks++;
        if (grant_ack_n !== 1'b1 || bus_master !== 1'b0) err("grant kept in reset");
        repeat (47) @(posedge clk);
        resetn <= 1'b1;
        chk_tbl(1'b1);
        claim(1'b0, 5'h04, 4, 0);
        wsig(4, 1'b1, 40);
        wsig(0, 1'b1, 4);
        $display("test hardware reset done");
        if (lo_q.size() != 0) err("grant missing");
        end_of_test();
    end
    initial begin
        #1ms;
        err("run timeout");
        end_of_test();
    end
endmodule : tb_shared_mem_arbiter_reset
`default_nettype wire
